/* File: core/sfl_freeze_lock.sv */
/*
 * sfl_freeze_lock: sanitize command interpreter with the freeze lock
 * subcommand, the sanitize state machine and the returned status fields.
 * assumes commands arrive as one-cycle strobes of a decoded command block,
 * an external engine runs overwrite and crypto operations, and rstn is
 * driven by both power-on and hardware reset.
 */
//
// Behaviour
// - accepted freeze lock moves the sanitize state machine to frozen
// - after freeze, every sanitize subcommand except status query is aborted
// - frozen state returns to idle only through power-on or hardware reset
// - count bit 15 reports completed without error; survives power-on reset
// - count bit 14 set while a sanitize operation is in progress
// - count bit 13 set while the state machine is frozen
// - progress high byte in cylinder low, low byte in sector number
// - progress reads all ones outside the operation state
// - progress is a numerator over an implied denominator of 65536
// - error reason code in sector number: 00h,01h,02h,03h
// - freeze lock answers aborted once a freeze lock has completed since the last power-on or hardware reset
// - status query is answered in every state, frozen included; in the failed state it answers aborted with reason 01h unless its count bit 0 is set
`timescale 1ns/100ps
`default_nettype none

module sfl_freeze_lock (
    input wire logic core_clk,
    input wire logic rstn,
    input wire sfl_pkg::sfl_cmd_type cmd,
    input wire sfl_pkg::sfl_engine_type engine,
    input wire logic nv_success,
    output sfl_pkg::sfl_resp_type resp,
    output logic engine_start,
    output logic nv_success_out
);
    import sfl_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    sfl_state_type state_q, state_d;
    logic success_q, success_d;
    logic loaded_q, loaded_d;
    logic freeze_seen_q, freeze_seen_d;
    logic start_q, start_d;
    sfl_resp_type resp_q, resp_d;

    // builds one command answer; progress and flags follow the current state
    function automatic sfl_resp_type build_resp(
        input sfl_state_type st,
        input logic succ,
        input logic abort,
        input logic [7:0] reason,
        input logic [15:0] prog
    );
        sfl_resp_type r;
        logic [15:0] p;
        r = '0;
        p = (st == sanitize_operation_state) ? prog : SFL_PROGRESS_NONE;
        r.done = 1'b1;
        r.command_error_flags[SFL_ERR_ABORT_BIT] = abort;
        r.command_status_flags[SFL_STAT_READY_BIT] = 1'b1;
        r.command_status_flags[SFL_STAT_SEEK_DONE_BIT] = 1'b1;
        r.command_status_flags[SFL_STAT_ERROR_BIT] = abort;
        r.sector_count[SFL_CNT_SUCCESS_BIT] = succ;
        r.sector_count[SFL_CNT_ACTIVE_BIT] = (st == sanitize_operation_state);
        r.sector_count[SFL_CNT_FROZEN_BIT] = (st == sanitize_frozen_state);
        r.cylinder_low = p[15:8];
        // on an abort the low byte carries the reason instead of progress
        r.sector_number = abort ? reason : p[7:0];
        return r;
    endfunction

    function automatic logic key_ok(input sfl_cmd_type c);
        return c.sector_number_cur == SFL_KEY_SECT_CUR
            && c.sector_number_prev == SFL_KEY_SECT_PREV
            && c.cylinder_low_cur == SFL_KEY_CYL_LOW_CUR
            && c.cylinder_high_cur == SFL_KEY_CYL_HIGH_CUR;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic is_san;
        logic frozen;
        sfl_state_type st;
        is_san = 1'b0;
        frozen = 1'b0;
        st = state_q;
        state_d = state_q;
        success_d = success_q;
        loaded_d = 1'b1;
        freeze_seen_d = freeze_seen_q;
        start_d = 1'b0;
        resp_d = resp_q;
        resp_d.done = 1'b0;

        // the success flag lives in non-volatile storage; catch it after release
        if (!loaded_q) begin
            success_d = nv_success;
        end

        // engine events first, so a command in the same cycle sees the result
        if (state_q == sanitize_operation_state) begin
            if (engine.end_ok) begin
                st = sanitize_succeeded_state;
                success_d = 1'b1;
            end else if (engine.end_fail) begin
                st = sanitize_failed_state;
            end
        end
        state_d = st;

        is_san = cmd.valid && cmd.opcode == SFL_OPCODE_SANITIZE;
        frozen = st == sanitize_frozen_state;

        if (is_san) begin
            unique case (cmd.feature)
                SFL_FEAT_STATUS: begin
                    // answered in every state, frozen included
                    if (cmd.sector_count[SFL_STATUS_CLEAR_FAIL_BIT]
                        && st == sanitize_failed_state) begin
                        state_d = sanitize_idle_state;
                        resp_d = build_resp(sanitize_idle_state, success_d, 1'b0,
                            SFL_REASON_NONE, engine.progress);
                    end else begin
                        resp_d = build_resp(st, success_d,
                            st == sanitize_failed_state,
                            st == sanitize_failed_state ? SFL_REASON_UNSUCCESSFUL
                                                       : SFL_REASON_NONE,
                            engine.progress);
                    end
                end
                SFL_FEAT_FREEZE: begin
                    if (frozen || freeze_seen_q) begin
                        // a repeat lock since the last power-on or hardware reset answers aborted
                        resp_d = build_resp(st, success_d, 1'b1, SFL_REASON_FROZEN,
                            engine.progress);
                    end else if (!key_ok(cmd)) begin
                        resp_d = build_resp(st, success_d, 1'b1, SFL_REASON_NONE,
                            engine.progress);
                    end else if (st == sanitize_operation_state) begin
                        // cannot lock under a running operation
                        resp_d = build_resp(st, success_d, 1'b1, SFL_REASON_NONE,
                            engine.progress);
                    end else begin
                        state_d = sanitize_frozen_state;
                        freeze_seen_d = 1'b1;
                        resp_d = build_resp(sanitize_frozen_state, success_d, 1'b0,
                            SFL_REASON_NONE, engine.progress);
                    end
                end
                SFL_FEAT_OVERWRITE, SFL_FEAT_CRYPTO: begin
                    if (frozen) begin
                        resp_d = build_resp(st, success_d, 1'b1, SFL_REASON_FROZEN,
                            engine.progress);
                    end else if (st == sanitize_operation_state) begin
                        resp_d = build_resp(st, success_d, 1'b1, SFL_REASON_NONE,
                            engine.progress);
                    end else begin
                        // engine takes the operation over; only its end_ok or end_fail report is read, begin_op is ignored
                        state_d = sanitize_operation_state;
                        success_d = 1'b0;
                        start_d = 1'b1;
                        resp_d = build_resp(sanitize_operation_state, 1'b0, 1'b0,
                            SFL_REASON_NONE, SFL_WORD_ZERO);
                    end
                end
                default: begin
                    resp_d = build_resp(st, success_d, 1'b1,
                        frozen ? SFL_REASON_FROZEN : SFL_REASON_BAD_FEATURE,
                        engine.progress);
                end
            endcase
        end
    end

    // only reset leaves the frozen state: no command path above exits it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= sanitize_idle_state;
            success_q <= 1'b0;
            loaded_q <= 1'b0;
            freeze_seen_q <= 1'b0;
            start_q <= 1'b0;
            resp_q <= '0;
        end else begin
            state_q <= state_d;
            success_q <= success_d;
            loaded_q <= loaded_d;
            freeze_seen_q <= freeze_seen_d;
            start_q <= start_d;
            resp_q <= resp_d;
        end
    end

    assign resp = resp_q;
    assign engine_start = start_q;
    assign nv_success_out = success_q;

endmodule

`default_nettype wire

/* File: core/sfl_pkg.sv */
/*
 * sfl_pkg: constants, command block and response carriers for the sanitize
 * freeze lock command interpreter.
 * assumes one controller clock domain; command block fields arrive decoded.
 */
package sfl_pkg;

    localparam logic [7:0] SFL_OPCODE_SANITIZE = 8'hb4;
    localparam logic [15:0] SFL_FEAT_STATUS = 16'h0000;
    localparam logic [15:0] SFL_FEAT_CRYPTO = 16'h0011;
    localparam logic [15:0] SFL_FEAT_OVERWRITE = 16'h0014;
    localparam logic [15:0] SFL_FEAT_FREEZE = 16'h0020;

    // fixed key bytes that must accompany the freeze lock subcommand
    localparam logic [7:0] SFL_KEY_SECT_CUR = 8'h6b;
    localparam logic [7:0] SFL_KEY_SECT_PREV = 8'h46;
    localparam logic [7:0] SFL_KEY_CYL_LOW_CUR = 8'h4c;
    localparam logic [7:0] SFL_KEY_CYL_HIGH_CUR = 8'h72;

    localparam int SFL_CNT_SUCCESS_BIT = 15;
    localparam int SFL_CNT_ACTIVE_BIT = 14;
    localparam int SFL_CNT_FROZEN_BIT = 13;
    localparam int SFL_STATUS_CLEAR_FAIL_BIT = 0;

    localparam int SFL_ERR_ABORT_BIT = 2;
    localparam int SFL_STAT_READY_BIT = 6;
    localparam int SFL_STAT_SEEK_DONE_BIT = 4;
    localparam int SFL_STAT_ERROR_BIT = 0;

    localparam logic [15:0] SFL_PROGRESS_NONE = 16'hffff;
    // progress is a numerator over this implied denominator
    localparam logic [16:0] SFL_PROGRESS_DENOM = 17'h10000;

    localparam logic [7:0] SFL_REASON_NONE = 8'h00;
    localparam logic [7:0] SFL_REASON_UNSUCCESSFUL = 8'h01;
    localparam logic [7:0] SFL_REASON_BAD_FEATURE = 8'h02;
    localparam logic [7:0] SFL_REASON_FROZEN = 8'h03;

    localparam logic [7:0] SFL_BYTE_ZERO = 8'h00;
    localparam logic [15:0] SFL_WORD_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        sanitize_idle_state,
        sanitize_frozen_state,
        sanitize_operation_state,
        sanitize_failed_state,
        sanitize_succeeded_state
    } sfl_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [15:0] feature;
        logic [15:0] sector_count;
        logic [7:0] sector_number_cur;
        logic [7:0] sector_number_prev;
        logic [7:0] cylinder_low_cur;
        logic [7:0] cylinder_high_cur;
    } sfl_cmd_type;

    typedef struct packed {
        logic done;
        logic [7:0] command_error_flags;
        logic [7:0] command_status_flags;
        logic [15:0] sector_count;
        logic [7:0] sector_number;
        logic [7:0] cylinder_low;
    } sfl_resp_type;

    typedef struct packed {
        logic begin_op;
        logic end_ok;
        logic end_fail;
        logic [15:0] progress;
    } sfl_engine_type;

endpackage

/* File: tb/sfl_freeze_lock_chk.sv */
/* sfl_freeze_lock_chk: port properties of the freeze lock interpreter.
   assumes binding to sfl_freeze_lock, one clock, async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module sfl_freeze_lock_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire sfl_pkg::sfl_cmd_type cmd,
    input wire sfl_pkg::sfl_engine_type engine,
    input wire logic nv_success,
    input wire sfl_pkg::sfl_resp_type resp,
    input wire logic engine_start,
    input wire logic nv_success_out
);
    import sfl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic take;
    logic ab;
    assign take = cmd.valid && cmd.opcode == SFL_OPCODE_SANITIZE;
    assign ab = resp.command_error_flags[SFL_ERR_ABORT_BIT];
    ////////////////////////////////////////////////////////////////////////
    chk_done_exact: assert property (take |=> resp.done)
        else $error("no answer one cycle after command");
    chk_no_extra: assert property (!take |=> !resp.done)
        else $error("answer without command");
    chk_freeze_enter: assert property (
        take && cmd.feature == SFL_FEAT_FREEZE |=> ab || resp.sector_count[13])
        else $error("accepted freeze lock not frozen");
    chk_frozen_abort: assert property (
        take && cmd.feature != SFL_FEAT_STATUS && resp.sector_count[13]
        |=> ab && resp.sector_number == SFL_REASON_FROZEN) else $error("frozen not aborted");
    chk_status_frozen: assert property (
        take && cmd.feature == SFL_FEAT_STATUS && resp.sector_count[13] |=> !ab)
        else $error("status refused while frozen");
    chk_frozen_hold: assert property (resp.sector_count[13] |=> resp.sector_count[13])
        else $error("left frozen without reset");
    chk_idle_ones: assert property (
        resp.done && !ab && !resp.sector_count[14]
        |-> {resp.cylinder_low, resp.sector_number} == SFL_PROGRESS_NONE)
        else $error("progress not all ones outside operation");
    // the answer that starts an operation reports zero progress, not the engine's
    chk_run_prog: assert property (
        resp.done && !ab && resp.sector_count[14] && !engine_start
        |-> {resp.cylinder_low, resp.sector_number} == $past(engine.progress))
        else $error("progress bytes misplaced");
    chk_start_zero: assert property (
        engine_start |-> {resp.cylinder_low, resp.sector_number} == SFL_WORD_ZERO)
        else $error("start answer progress not zero");
    chk_abort_flag: assert property (resp.done |-> resp.command_status_flags[0] == ab)
        else $error("error bit differs from abort");
    chk_start_pulse: assert property (
        engine_start |-> resp.done && resp.sector_count[14] ##1 !engine_start)
        else $error("engine start not a one-cycle pulse");
endmodule
`default_nettype wire

/* File: tb/sfl_host.sv */
/* sfl_host: host side model issuing sanitize commands.
   assumes answers are registered on the taking edge; seen is read 1 ns after it. */
`timescale 1ns/100ps
`default_nettype none
module sfl_host (
    input wire logic core_clk,
    input wire sfl_pkg::sfl_resp_type resp,
    output var sfl_pkg::sfl_cmd_type cmd,
    output var sfl_pkg::sfl_resp_type seen
);
    import sfl_pkg::*;
    initial cmd = '0;
    // released lines show the inverse, so a stale copy cannot pass
    task automatic send(input logic [15:0] f, input logic key_ok, input logic [15:0] sc);
        logic [7:0] m;
        m = key_ok ? 8'h00 : 8'hff;
        @(posedge core_clk);
        cmd <= '{1'b1, SFL_OPCODE_SANITIZE, f, sc, SFL_KEY_SECT_CUR ^ m,
            SFL_KEY_SECT_PREV ^ m, SFL_KEY_CYL_LOW_CUR ^ m, SFL_KEY_CYL_HIGH_CUR ^ m};
        @(posedge core_clk);
        cmd <= {1'b0, ~cmd[71:0]};
        #1 seen = resp;
    endtask
endmodule
`default_nettype wire

/* File: tb/sfl_freeze_lock_tb.sv */
/* sfl_freeze_lock_tb: self-checking bench for the freeze lock interpreter.
   assumes sfl_host as command partner; the bench plays the engine. */
`timescale 1ns/100ps
`default_nettype none
module sfl_freeze_lock_tb;
    import sfl_pkg::*;
    logic core_clk, rstn, nv_success, engine_start, nv_success_out;
    sfl_cmd_type cmd;
    sfl_engine_type engine;
    sfl_resp_type resp, seen;
    int n_fail = 0;
    int compares = 0;
    logic [36:0] rows [3];
    logic [15:0] fz [4] = '{SFL_FEAT_OVERWRITE, SFL_FEAT_CRYPTO, SFL_FEAT_FREEZE, 16'h0055};
    sfl_freeze_lock i_sfl_freeze_lock (.core_clk(core_clk), .rstn(rstn), .cmd(cmd),
        .engine(engine), .nv_success(nv_success), .resp(resp),
        .engine_start(engine_start), .nv_success_out(nv_success_out));
    sfl_host i_sfl_host (.core_clk(core_clk), .resp(resp), .cmd(cmd), .seen(seen));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic run(input logic [15:0] f, input logic k, input logic [15:0] sc,
        input logic ab, input logic [15:0] e, input logic [2:0] b);
        i_sfl_host.send(f, k, sc);
        chk("done", 16'h0001, {15'h0, seen.done});
        chk("abort", {15'h0, ab}, {15'h0, seen.command_error_flags[SFL_ERR_ABORT_BIT]});
        chk("count", {13'h0, b}, {13'h0, seen.sector_count[15:13]});
        if (ab) chk("reason", e, {8'h00, seen.sector_number});
        else chk("progress", e, {seen.cylinder_low, seen.sector_number});
    endtask
    task automatic reset_pulse(input logic nv);
        @(posedge core_clk);
        rstn <= 1'b0;
        nv_success <= nv;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic pulse_end(input logic ok);
        @(posedge core_clk);
        engine.end_ok <= ok;
        engine.end_fail <= !ok;
        @(posedge core_clk);
        engine.end_ok <= 1'b0;
        engine.end_fail <= 1'b0;
    endtask
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        nv_success = 1'b0;
        engine = '0;
        engine.progress = 16'h1234;
        rows[0] = {SFL_FEAT_STATUS, 1'b1, 1'b0, SFL_PROGRESS_NONE, 3'b000};
        rows[1] = {16'h0055, 1'b1, 1'b1, 16'h0002, 3'b000};
        rows[2] = {SFL_FEAT_FREEZE, 1'b0, 1'b1, 16'h0000, 3'b000};
        reset_pulse(1'b0);
        foreach (rows[i]) run(rows[i][36:21], rows[i][20], 16'h0000, rows[i][19],
            rows[i][18:3], rows[i][2:0]);
        $display("test rows done");
        run(SFL_FEAT_FREEZE, 1'b1, 16'h0000, 1'b0, SFL_PROGRESS_NONE, 3'b001);
        foreach (fz[i]) run(fz[i], 1'b1, 16'h0000, 1'b1, 16'h0003, 3'b001);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b0, SFL_PROGRESS_NONE, 3'b001);
        reset_pulse(1'b0);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b0, SFL_PROGRESS_NONE, 3'b000);
        $display("test freeze done");
        // the accepting answer reports zero progress; the engine's value follows
        run(SFL_FEAT_OVERWRITE, 1'b1, 16'h0000, 1'b0, 16'h0000, 3'b010);
        chk("start", 16'h0001, {15'h0, engine_start});
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b0, 16'h1234, 3'b010);
        run(SFL_FEAT_FREEZE, 1'b1, 16'h0000, 1'b1, 16'h0000, 3'b010);
        pulse_end(1'b1);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b0, SFL_PROGRESS_NONE, 3'b100);
        chk("stored", 16'h0001, {15'h0, nv_success_out});
        reset_pulse(1'b1);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b0, SFL_PROGRESS_NONE, 3'b100);
        run(SFL_FEAT_OVERWRITE, 1'b1, 16'h0000, 1'b0, 16'h0000, 3'b010);
        pulse_end(1'b0);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0000, 1'b1, 16'h0001, 3'b000);
        run(SFL_FEAT_STATUS, 1'b1, 16'h0001, 1'b0, SFL_PROGRESS_NONE, 3'b000);
        $display("test engine done");
        test_done;
    end
    // whole run is under a hundred cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        $display("ERROR watchdog expected end seen hang");
        test_done;
    end
endmodule
bind sfl_freeze_lock sfl_freeze_lock_chk i_sfl_freeze_lock_chk (.core_clk(core_clk),
    .rstn(rstn), .cmd(cmd), .engine(engine), .nv_success(nv_success), .resp(resp),
    .engine_start(engine_start), .nv_success_out(nv_success_out));
`default_nettype wire
